// ==== hw/ddh_holding_regs.sv ====
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// - Register 0x14 holds second channel value right aligned in bits 11:0.
// - Register 0x18 holds second channel value left aligned in bits 15:4.
// - Register 0x1C bits 7:0 give the second channel's eight top bits.
// - Register 0x20 loads second channel from 27:16, first from 11:0.
// - Register 0x24 loads second channel from 31:20, first from 15:4.
// - Every holding register resets to all zeros.
// - Each channel keeps a read-only converting value loaded from its holding value.
module ddh_holding_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,                     // Bus clock, 250 MHz.
  input wire logic rst_i,                     // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid,             // Write address valid.
  output logic s_axi_awready,                 // Write address ready.
  input wire logic [31:0] s_axi_wdata,        // Write data.
  input wire logic [3:0] s_axi_wstrb,         // Write byte strobes.
  input wire logic s_axi_wvalid,              // Write data valid.
  output logic s_axi_wready,                  // Write data ready.
  output logic [1:0] s_axi_bresp,             // Write response.
  output logic s_axi_bvalid,                  // Write response valid.
  input wire logic s_axi_bready,              // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid,             // Read address valid.
  output logic s_axi_arready,                 // Read address ready.
  output logic [31:0] s_axi_rdata,            // Read data.
  output logic [1:0] s_axi_rresp,             // Read response.
  output logic s_axi_rvalid,                  // Read data valid.
  input wire logic s_axi_rready,              // Read data ready.
  output logic [ddh_pkg::DDH_VALUE_W-1:0] first_channel_converting_value_o,  // First channel value in conversion.
  output logic [ddh_pkg::DDH_VALUE_W-1:0] second_channel_converting_value_o  // Second channel value in conversion.
);
  import ddh_pkg::*;

  // The decode compares eight address bits, so a narrower bus cannot reach the map.
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  typedef logic [DDH_VALUE_W-1:0] ddh_value_type;

  // Places a channel value in a register word for a read, reserved bits zero.
  function automatic logic [31:0] ddh_read_word(input logic [7:0] ofs, input ddh_value_type ch0,
                                                input ddh_value_type ch1);
    logic [31:0] w;
    w = DDH_WORD_RESET;
    case (ofs)
      DDH_CH1_RIGHT12_HOLD_OFS: w[DDH_RIGHT12_LSB +: DDH_VALUE_W] = ch1;
      DDH_CH1_LEFT12_HOLD_OFS: w[DDH_LEFT12_LSB +: DDH_VALUE_W] = ch1;
      DDH_CH1_MSB8_HOLD_OFS: w[DDH_MSB8_LSB +: DDH_BYTE_W] = ch1[DDH_VALUE_W-1 -: DDH_BYTE_W];
      DDH_DUAL_RIGHT12_HOLD_OFS: begin
        w[DDH_DUAL_HI_RIGHT12_LSB +: DDH_VALUE_W] = ch1;
        w[DDH_DUAL_LO_RIGHT12_LSB +: DDH_VALUE_W] = ch0;
      end
      DDH_DUAL_LEFT12_HOLD_OFS: begin
        w[DDH_DUAL_HI_LEFT12_LSB +: DDH_VALUE_W] = ch1;
        w[DDH_DUAL_LO_LEFT12_LSB +: DDH_VALUE_W] = ch0;
      end
      default: w = DDH_WORD_RESET;
    endcase
    return w;
  endfunction

  // True for any of the five mapped offsets.
  function automatic logic ddh_mapped(input logic [7:0] ofs);
    return (ofs == DDH_CH1_RIGHT12_HOLD_OFS) || (ofs == DDH_CH1_LEFT12_HOLD_OFS) ||
           (ofs == DDH_CH1_MSB8_HOLD_OFS) || (ofs == DDH_DUAL_RIGHT12_HOLD_OFS) ||
           (ofs == DDH_DUAL_LEFT12_HOLD_OFS);
  endfunction

  ddh_value_type first_channel_hold_value_q;
  ddh_value_type second_channel_hold_value_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] wr_ofs_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_ch0_q;
  logic wr_ch1_q;

  // Address and data are latched separately so they may arrive in either order.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_word_ok = ddh_mapped(wr_ofs_q) & (wr_strb_q == DDH_STRB_FULL);
  wire wr_commit = do_write & wr_word_ok;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_ofs = s_axi_araddr[7:0];

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  // Which channel a committed write touches, and the value each format carries.
  wire wr_dual = (wr_ofs_q == DDH_DUAL_RIGHT12_HOLD_OFS) | (wr_ofs_q == DDH_DUAL_LEFT12_HOLD_OFS);
  wire wr_ch0 = wr_commit & wr_dual;
  wire wr_ch1 = wr_commit;
  wire ddh_value_type ch1_right = wr_data_q[DDH_RIGHT12_LSB +: DDH_VALUE_W];
  wire ddh_value_type ch1_left = wr_data_q[DDH_LEFT12_LSB +: DDH_VALUE_W];
  wire ddh_value_type ch1_msb8 = {wr_data_q[DDH_MSB8_LSB +: DDH_BYTE_W], 4'h0};
  wire ddh_value_type ch1_dual_r = wr_data_q[DDH_DUAL_HI_RIGHT12_LSB +: DDH_VALUE_W];
  wire ddh_value_type ch1_dual_l = wr_data_q[DDH_DUAL_HI_LEFT12_LSB +: DDH_VALUE_W];
  wire ddh_value_type ch0_dual_r = wr_data_q[DDH_DUAL_LO_RIGHT12_LSB +: DDH_VALUE_W];
  wire ddh_value_type ch0_dual_l = wr_data_q[DDH_DUAL_LO_LEFT12_LSB +: DDH_VALUE_W];

  // Every format of one channel lands in the same holding value.
  wire ddh_value_type ch1_new =
    (wr_ofs_q == DDH_CH1_RIGHT12_HOLD_OFS) ? ch1_right :
    (wr_ofs_q == DDH_CH1_LEFT12_HOLD_OFS) ? ch1_left :
    (wr_ofs_q == DDH_CH1_MSB8_HOLD_OFS) ? ch1_msb8 :
    (wr_ofs_q == DDH_DUAL_RIGHT12_HOLD_OFS) ? ch1_dual_r : ch1_dual_l;
  wire ddh_value_type ch0_new = (wr_ofs_q == DDH_DUAL_RIGHT12_HOLD_OFS) ? ch0_dual_r : ch0_dual_l;

  // Holding values; a partial-strobe write is dropped because it could not form a whole value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_channel_hold_value_q <= DDH_HOLD_RESET;
      second_channel_hold_value_q <= DDH_HOLD_RESET;
    end else begin
      if (wr_ch0) begin
        first_channel_hold_value_q <= ch0_new;
      end
      if (wr_ch1) begin
        second_channel_hold_value_q <= ch1_new;
      end
    end
  end

  // Write address and data capture.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      wr_data_q <= DDH_WORD_RESET;
      wr_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        wr_ofs_q <= s_axi_awaddr[7:0];
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped or partial writes answer with a slave error.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= DDH_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_word_ok ? DDH_RESP_OKAY : DDH_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel; the word is formed from live holding values when the address is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= DDH_WORD_RESET;
      rresp_q <= DDH_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= ddh_read_word(rd_ofs, first_channel_hold_value_q, second_channel_hold_value_q);
      rresp_q <= ddh_mapped(rd_ofs) ? DDH_RESP_OKAY : DDH_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Converting values follow the holding values one clock after each update.
  ddh_convert_latch #(
    .VALUE_W(DDH_VALUE_W)
  ) u_conv_first (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(wr_ch0_q),
    .hold_i(first_channel_hold_value_q),
    .conv_o(first_channel_converting_value_o)
  );

  ddh_convert_latch #(
    .VALUE_W(DDH_VALUE_W)
  ) u_conv_second (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(wr_ch1_q),
    .hold_i(second_channel_hold_value_q),
    .conv_o(second_channel_converting_value_o)
  );

  // Delayed strobes so the latch sees the holding value after it has settled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ch0_q <= 1'b0;
      wr_ch1_q <= 1'b0;
    end else begin
      wr_ch0_q <= wr_ch0;
      wr_ch1_q <= wr_ch1;
    end
  end
endmodule

// ==== hw/ddh_pkg.sv ====
package ddh_pkg;

  // Register byte offsets; every printed offset is word aligned.
  localparam logic [7:0] DDH_CH1_RIGHT12_HOLD_OFS = 8'h14;
  localparam logic [7:0] DDH_CH1_LEFT12_HOLD_OFS = 8'h18;
  localparam logic [7:0] DDH_CH1_MSB8_HOLD_OFS = 8'h1c;
  localparam logic [7:0] DDH_DUAL_RIGHT12_HOLD_OFS = 8'h20;
  localparam logic [7:0] DDH_DUAL_LEFT12_HOLD_OFS = 8'h24;

  // Field positions (least significant bit of each field).
  localparam int DDH_RIGHT12_LSB = 0;
  localparam int DDH_LEFT12_LSB = 4;
  localparam int DDH_MSB8_LSB = 0;
  localparam int DDH_DUAL_HI_RIGHT12_LSB = 16;
  localparam int DDH_DUAL_HI_LEFT12_LSB = 20;
  localparam int DDH_DUAL_LO_RIGHT12_LSB = 0;
  localparam int DDH_DUAL_LO_LEFT12_LSB = 4;

  // Widths and reset values.
  localparam int DDH_VALUE_W = 12;
  localparam int DDH_BYTE_W = 8;
  localparam logic [11:0] DDH_HOLD_RESET = 12'h000;
  localparam logic [31:0] DDH_WORD_RESET = 32'h0000_0000;

  // AXI4-Lite response codes and the full-word strobe.
  localparam logic [1:0] DDH_RESP_OKAY = 2'b00;
  localparam logic [1:0] DDH_RESP_SLVERR = 2'b10;
  localparam logic [3:0] DDH_STRB_FULL = 4'hf;

endpackage

// ==== hw/ddh_convert_latch.sv ====
`timescale 1ns/1ns
module ddh_convert_latch #(
  parameter int VALUE_W = 12
) (
  input wire logic clk_i,                 // Bus clock.
  input wire logic rst_i,                 // Synchronous reset, active high.
  input wire logic load_i,                // Pulse: holding value was just updated.
  input wire logic [VALUE_W-1:0] hold_i,  // Current holding value.
  output logic [VALUE_W-1:0] conv_o       // Value being converted, read only.
);
  import ddh_pkg::*;

  // A zero-width value would leave the converter with nothing to hold.
  if (VALUE_W < 1) begin : g_width_check
    $error("VALUE_W must be at least 1");
  end

  logic [VALUE_W-1:0] conv_q;

  // With no trigger logic in this block, the holding value moves to the converter one clock after each update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_q <= '0;
    end else if (load_i) begin
      conv_q <= hold_i;
    end
  end

  assign conv_o = conv_q;
endmodule

// ==== sim/ddh_regs_sva.sv ====
`timescale 1ns/1ns
module ddh_regs_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,                                                    // Bus clock.
  input wire logic rst_i,                                                    // Synchronous reset.
  input wire logic [ADDR_W-1:0] s_axi_araddr,                                // Read address.
  input wire logic s_axi_arvalid,                                            // Read address valid.
  input wire logic s_axi_arready,                                            // Read address ready.
  input wire logic [31:0] s_axi_rdata,                                       // Read data.
  input wire logic [1:0] s_axi_rresp,                                        // Read response.
  input wire logic s_axi_rvalid,                                             // Read data valid.
  input wire logic s_axi_bvalid,                                             // Write response valid.
  input wire logic [ddh_pkg::DDH_VALUE_W-1:0] first_channel_converting_value_o,  // Channel 0 value.
  input wire logic [ddh_pkg::DDH_VALUE_W-1:0] second_channel_converting_value_o  // Channel 1 value.
);
  import ddh_pkg::*;
  // One clock domain, so clock and reset are given once for all properties.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read images keep reserved positions at zero; a stray bit here means a wrong alignment.
  AST_RD_RIGHT12: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h14
    |=> s_axi_rvalid && s_axi_rdata[31:12] == 20'h00000) else $error("right aligned image has bits above 11");
  AST_RD_LEFT12: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h18
    |=> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[3:0] == 4'h0) else $error("left aligned image misplaced");
  AST_RD_MSB8: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h1c
    |=> s_axi_rdata[31:8] == 24'h000000) else $error("byte image has bits above 7");
  AST_RD_DUAL_RIGHT: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h20
    |=> s_axi_rdata[31:28] == 4'h0 && s_axi_rdata[15:12] == 4'h0) else $error("dual right image misplaced");
  AST_RD_DUAL_LEFT: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h24
    |=> s_axi_rdata[19:16] == 4'h0 && s_axi_rdata[3:0] == 4'h0) else $error("dual left image misplaced");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == 8'h28
    |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == DDH_RESP_SLVERR) else $error("unmapped read not refused");
  AST_RESET_IDLE: assert property ($fell(rst_i) |-> !s_axi_bvalid && !s_axi_rvalid
    && first_channel_converting_value_o == 12'h000 && second_channel_converting_value_o == 12'h000)
    else $error("state not cleared by reset");
  // The converting value may only move right after a write was answered.
  AST_CONV_CAUSE: assert property (!$stable(first_channel_converting_value_o)
    || !$stable(second_channel_converting_value_o) |-> $past(s_axi_bvalid)) else $error("output moved without write");
endmodule
bind ddh_holding_regs ddh_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_i, .rst_i, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .first_channel_converting_value_o,
  .second_channel_converting_value_o);

// ==== sim/ddh_holding_regs_tb.sv ====
`timescale 1ns/1ns
module ddh_holding_regs_tb;
  import ddh_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [11:0] conv0, conv1;
  int miscompares = 0;
  int tests_run = 0;
  // Write table; the last two entries must be refused and leave both channels alone.
  logic [7:0] t_a [7] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h14};
  logic [31:0] t_d [7] = '{32'h0000_0abc, 32'h0000_5670, 32'h0000_009d, 32'h0123_0456, 32'hfed0_cba0,
    32'h0000_0fff, 32'h0000_0111};
  logic [3:0] t_s [7] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3};
  logic [23:0] t_e [7] = '{24'habc000, 24'h567000, 24'h9d0000, 24'h123456, 24'hfedcba, 24'hfedcba, 24'hfedcba};
  logic [7:0] r_a [6] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};

  ddh_holding_regs #(.ADDR_W(8)) dut_u (.clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .first_channel_converting_value_o(conv0), .second_channel_converting_value_o(conv1));

  // Free running 250 MHz bus clock.
  always #2 clk_i = ~clk_i;

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // Expected read image of a channel pair, built independently of the design.
  function automatic logic [31:0] img(input logic [7:0] a, input logic [11:0] c1, input logic [11:0] c0);
    case (a)
      8'h14: return {20'h00000, c1};
      8'h18: return {16'h0000, c1, 4'h0};
      8'h1c: return {24'h000000, c1[11:4]};
      8'h20: return {4'h0, c1, 4'h0, c0};
      8'h24: return {c1, 4'h0, c0, 4'h0};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Address and data are offered together; each is dropped at its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    if (n >= 50) begin
      chk("write handshake", 32'h1, 32'h0);
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    if (n >= 50) begin
      chk("read handshake", 32'h1, 32'h0);
      print_verdict();
    end
  endtask

  // Reads every image plus one unmapped word, then both converting values.
  task automatic chk_all(input logic [23:0] e);
    for (int j = 0; j < 6; j++) begin
      rd(r_a[j], (j == 5) ? DDH_RESP_SLVERR : DDH_RESP_OKAY);
      chk("rdata", img(r_a[j], e[23:12], e[11:0]), rd_d);
    end
    chk("second converting value", 32'(e[23:12]), 32'(conv1));
    chk("first converting value", 32'(e[11:0]), 32'(conv0));
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Reset, walk every write format, then reset mid-run to show the holding values clear again.
  initial begin
    do_reset();
    chk_all(24'h000000);
    for (int i = 0; i < 7; i++) begin
      wr(t_a[i], t_d[i], t_s[i], (i < 5) ? DDH_RESP_OKAY : DDH_RESP_SLVERR);
      chk_all(t_e[i]);
    end
    do_reset();
    chk_all(24'h000000);
    print_verdict();
  end
endmodule
